// File: logic/irq_gate_defines.svh
/*
 constants for the channel interrupt enable block: register offsets, bit positions,
 reset values and timing counts. assumes inclusion by bare name.
*/
`ifndef IRQ_GATE_DEFINES_SVH
`define IRQ_GATE_DEFINES_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_MASK 12'h008
`define OFF_MODE 12'h00c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_RSVD_LO 5
`define CTRL_RSVD_HI 11
`define CTRL_CPL_EN 12
`define CTRL_DLY_EN 13
`define CTRL_ERR_EN 14
`define CTRL_THR_LO 16
`define CTRL_THR_HI 23
`define CTRL_DLYV_LO 24
`define CTRL_DLYV_HI 31
`define CTRL_WMASK 32'hffff7000
`define CTRL_RESET 32'h00010000

// ----------------------------------------------------------------
// status / mask bit positions (same layout)
// ----------------------------------------------------------------
`define ST_CPL 0
`define ST_DLY 1
`define ST_ERR 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TICK_PERIODS 125
`define CLK_NS 5
`define ZERO8 8'h00
`define ONE8 8'h01

`endif

// File: logic/irq_gate_pkg.sv
/*
 types for the channel interrupt enable block.
 assumes the defines header is compiled alongside.
*/
package irq_gate_pkg;
   typedef logic [31:0] word_t;
   typedef logic [2:0] src_t;
endpackage : irq_gate_pkg

// File: logic/delay_timer.sv
/*
 delay timer: counts idle time after a packet end in ticks of 125 clocks and
 pulses on expiry. assumes pkt_start and pkt_end are one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
`include "irq_gate_defines.svh"

module delay_timer #(
   parameter int TICK = `TICK_PERIODS
)(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // control
   input wire logic [7:0] delay_value,
   input wire logic pkt_start,
   input wire logic pkt_end,
   // event
   output logic timeout
);
   logic [7:0] tick_q;
   logic [7:0] ticks_q;
   logic run_q;
   logic tick_end;

   assign tick_end = (tick_q == 8'(TICK - 1));

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   // a zero delay value disables the timer altogether
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         run_q <= 1'b0;
      else if (pkt_start || timeout || delay_value == `ZERO8)
         run_q <= 1'b0;
      else if (pkt_end)
         run_q <= 1'b1;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         tick_q <= `ZERO8;
         ticks_q <= `ZERO8;
      end
      else if (!run_q || pkt_end)
      begin
         tick_q <= `ZERO8;
         ticks_q <= `ZERO8;
      end
      else if (tick_end)
      begin
         tick_q <= `ZERO8;
         ticks_q <= ticks_q + `ONE8;
      end
      else
         tick_q <= tick_q + `ONE8;
   end

   assign timeout = run_q && tick_end && (ticks_q + `ONE8 == delay_value);
endmodule : delay_timer
`default_nettype wire

// File: logic/irq_gate.sv
/*
 interrupt enable gating for the memory-to-stream channel, with status, mask,
 completion threshold and delay timer, reached over apb.
 registers: control, write-one-to-clear status, mask of the status layout, mode.
 assumes event inputs are one-cycle pulses synchronous to mclk, an apb master
 that holds each request through its access cycle, and software that sets both
 the enable and the mask bit of a source before expecting its interrupt.
*/
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "irq_gate_defines.svh"

module irq_gate
#(
   parameter int TICK = `TICK_PERIODS
)(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire irq_gate_pkg::word_t pwdata,
   output irq_gate_pkg::word_t prdata,
   output logic pready,
   output logic pslverr,
   // engine events
   input wire logic cpl_event,
   input wire logic err_event,
   input wire logic pkt_start,
   input wire logic pkt_end,
   // interrupt
   output logic irq
);
   import irq_gate_pkg::*;

   word_t ctrl_q;
   src_t status_q;
   src_t mask_q;
   logic sg_mode_q;
   logic [7:0] count_q;
   logic wr;
   logic hit;
   logic ctrl_wr;
   logic status_wr;
   logic mask_wr;
   logic mode_wr;
   logic thr_load;
   logic dly_event;
   logic cpl_flag_set;
   src_t set_v;
   src_t clr_v;
   src_t enable_v;
   word_t rdata_d;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // pready is tied high: every transfer ends after its first access cycle
   assign wr = psel && penable && pwrite;
   assign ctrl_wr = wr && (paddr == `OFF_CTRL);
   assign status_wr = wr && (paddr == `OFF_STATUS);
   assign mask_wr = wr && (paddr == `OFF_MASK);
   assign mode_wr = wr && (paddr == `OFF_MODE);
   // a zero threshold is not a legal setting, so such a write keeps the old one
   assign thr_load = ctrl_wr && (pwdata[`CTRL_THR_HI:`CTRL_THR_LO] != `ZERO8);

   always_comb
   begin
      case (paddr)
         `OFF_CTRL, `OFF_STATUS, `OFF_MASK, `OFF_MODE: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   // only writable fields are stored, so reserved bits stay zero
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         ctrl_q <= `CTRL_RESET;
      else if (ctrl_wr)
      begin
         ctrl_q[`CTRL_ERR_EN:`CTRL_CPL_EN] <= pwdata[`CTRL_ERR_EN:`CTRL_CPL_EN];
         ctrl_q[`CTRL_DLYV_HI:`CTRL_DLYV_LO] <= pwdata[`CTRL_DLYV_HI:`CTRL_DLYV_LO];
         if (thr_load)
            ctrl_q[`CTRL_THR_HI:`CTRL_THR_LO] <= pwdata[`CTRL_THR_HI:`CTRL_THR_LO];
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         mask_q <= '0;
      else if (mask_wr)
         mask_q <= pwdata[2:0];
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         sg_mode_q <= 1'b0;
      else if (mode_wr)
         sg_mode_q <= pwdata[0];
   end

   // ----------------------------------------------------------------
   // completion threshold
   // ----------------------------------------------------------------
   // reloads on a threshold write so a new setting takes effect at once
   // the count runs only in scatter-gather mode; direct mode ignores the threshold
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         count_q <= `ONE8;
      else if (thr_load)
         count_q <= pwdata[`CTRL_THR_HI:`CTRL_THR_LO];
      else if (cpl_event && sg_mode_q)
      begin
         if (count_q == `ONE8)
            count_q <= ctrl_q[`CTRL_THR_HI:`CTRL_THR_LO];
         else
            count_q <= count_q - `ONE8;
      end
   end

   // direct mode raises the flag on every completion
   assign cpl_flag_set = cpl_event && (!sg_mode_q || count_q == `ONE8);

   // ----------------------------------------------------------------
   // delay timer
   // ----------------------------------------------------------------
   // direct mode starts no timer run, but a run begun in scatter-gather mode still times out and sets the delay flag
   delay_timer #(
      .TICK(TICK)
   ) u_timer (
      .mclk(mclk),
      .resetn(resetn),
      .delay_value(ctrl_q[`CTRL_DLYV_HI:`CTRL_DLYV_LO]),
      .pkt_start(pkt_start && sg_mode_q),
      .pkt_end(pkt_end && sg_mode_q),
      .timeout(dly_event)
   );

   // ----------------------------------------------------------------
   // sticky status, write one to clear, set wins
   // ----------------------------------------------------------------
   assign set_v = {err_event, dly_event, cpl_flag_set};
   assign clr_v = status_wr ? pwdata[2:0] : 3'h0;

   // an event landing on the same edge as its clear must not be lost
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_flag
         always_ff @(posedge mclk or negedge resetn)
         begin
            if (!resetn)
               status_q[i] <= 1'b0;
            else if (set_v[i])
               status_q[i] <= 1'b1;
            else if (clr_v[i])
               status_q[i] <= 1'b0;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // interrupt gating
   // ----------------------------------------------------------------
   // the delay source only counts in scatter-gather mode
   assign enable_v[`ST_CPL] = ctrl_q[`CTRL_CPL_EN];
   assign enable_v[`ST_DLY] = ctrl_q[`CTRL_DLY_EN] && sg_mode_q;
   assign enable_v[`ST_ERR] = ctrl_q[`CTRL_ERR_EN];

   // registered so the host sees a clean level, one edge after the flag
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         irq <= 1'b0;
      else
         irq <= |(status_q & enable_v & mask_q);
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // unmapped offsets read as zero
   always_comb
   begin
      rdata_d = '0;
      case (paddr)
         `OFF_CTRL: rdata_d = ctrl_q & `CTRL_WMASK;
         `OFF_STATUS: rdata_d = {29'h0, status_q};
         `OFF_MASK: rdata_d = {29'h0, mask_q};
         `OFF_MODE: rdata_d = {31'h0, sg_mode_q};
         default: rdata_d = '0;
      endcase
   end

   // captured in the setup cycle, so the word is settled for the whole access
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
         prdata <= rdata_d;
   end
endmodule : irq_gate
`default_nettype wire

// File: tb/irq_host_model.sv
/* host side: processor interrupt input, counts rising edges of irq.
 assumes irq is a level synchronous to mclk. */
`timescale 1ns/10ps
`default_nettype none
module irq_host_model (
   // clock, reset, interrupt
   input wire logic mclk,
   input wire logic resetn,
   input wire logic irq,
   output logic [7:0] rise_cnt_q
);
   logic irq_q;
   // edges, not levels, so a stuck irq counts once
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         irq_q <= 1'b0;
         rise_cnt_q <= 8'h00;
      end
      else
      begin
         irq_q <= irq;
         if (irq && !irq_q)
            rise_cnt_q <= rise_cnt_q + 8'h01;
      end
endmodule : irq_host_model
`default_nettype wire

// File: tb/irq_gate_monitor.sv
/* assertions on the irq_gate ports, with shadow copies of enables and mask.
 assumes no register write coincides with an event pulse. */
`timescale 1ns/10ps
`default_nettype none
`include "irq_gate_defines.svh"
module irq_gate_monitor
   import irq_gate_pkg::*;
#(parameter int TICK = 125)(
   // clock, reset, apb
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire irq_gate_pkg::word_t pwdata,
   input wire irq_gate_pkg::word_t prdata,
   input wire logic pready,
   input wire logic pslverr,
   // events, interrupt
   input wire logic cpl_event,
   input wire logic err_event,
   input wire logic pkt_start,
   input wire logic pkt_end,
   input wire logic irq
);
   localparam int DLY_MAX = TICK + 8;
   logic [2:0] en_q;
   logic [2:0] mask_q;
   logic sg_q;
   logic [7:0] dly_q;
   logic [7:0] thr_q;
   logic [7:0] cnt_q;
   wire wr = psel & penable & pwrite;
   wire rd_ctrl = psel & penable & !pwrite & (paddr == `OFF_CTRL);
   wire [2:0] eff = en_q & mask_q & {1'b1, sg_q, 1'b1};
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         en_q <= 3'h0;
         mask_q <= 3'h0;
         sg_q <= 1'b0;
         dly_q <= 8'h00;
         thr_q <= 8'h01;
         cnt_q <= 8'h01;
      end
      else
      begin
         if (wr && paddr == `OFF_CTRL)
         begin
            en_q <= pwdata[`CTRL_ERR_EN:`CTRL_CPL_EN];
            dly_q <= pwdata[31:24];
            if (pwdata[23:16] != 8'h00)
            begin
               thr_q <= pwdata[23:16];
               cnt_q <= pwdata[23:16];
            end
         end
         else if (sg_q && cpl_event)
            cnt_q <= (cnt_q == 8'h01) ? thr_q : cnt_q - 8'h01;
         if (wr && paddr == `OFF_MASK)
            mask_q <= pwdata[2:0];
         if (wr && paddr == `OFF_MODE)
            sg_q <= pwdata[0];
      end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_rsvd_read_zero: assert property (rd_ctrl |-> prdata[11:5] == 7'h00)
      else $error("reserved control bits read nonzero");
   a_en_read_back: assert property (rd_ctrl |-> prdata[14:12] == en_q)
      else $error("enable bits read back wrong");
   a_cpl_raises_irq: assert property (cpl_event && (!sg_q || cnt_q == 8'h01)
      && en_q[0] && mask_q[0] |-> ##2 irq) else $error("completion did not raise irq");
   a_thr_holds_off: assert property (sg_q && cpl_event && cnt_q != 8'h01 && !irq
      |-> ##2 !irq) else $error("irq before threshold count ran out");
   a_err_raises_irq: assert property (err_event && en_q[2] && mask_q[2] |-> ##2 irq)
      else $error("error did not raise irq");
   a_irq_needs_en: assert property (irq |-> $past(eff) != 3'h0)
      else $error("irq without an effective enable");
   a_dly_timeout: assert property (disable iff (!resetn || pkt_start)
      sg_q && pkt_end && dly_q == 8'h01 && eff[1] && !irq
      |=> !irq [*3] ##[1:DLY_MAX] irq) else $error("delay timeout off time");
   a_reset_quiet: assert property ($rose(resetn) |-> !irq)
      else $error("irq high after reset");
   c_irq_rise: cover property ($rose(irq));
   c_sg_cpl: cover property (sg_q && cpl_event);
   c_bad_addr: cover property (pslverr);
endmodule : irq_gate_monitor
bind irq_gate irq_gate_monitor #(.TICK(TICK)) irq_gate_monitor_i (.mclk(mclk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpl_event(cpl_event),
   .err_event(err_event), .pkt_start(pkt_start), .pkt_end(pkt_end), .irq(irq));
`default_nettype wire

// File: tb/tb.sv
/* bench for irq_gate: apb tasks, event pulses, interrupt checks.
 assumes the bound checker and the host model beside the design. */
`timescale 1ns/10ps
`default_nettype none
`include "irq_gate_defines.svh"
module tb;
   import irq_gate_pkg::*;
   localparam int TICK = 5;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   word_t pwdata = 32'h00000000;
   logic [3:0] ev = 4'h0;
   word_t prdata;
   word_t rd;
   logic slverr;
   logic pready;
   logic pslverr;
   logic irq;
   logic [7:0] rises;
   int fail_count = 0;
   int samples_checked = 0;
   int n;
   irq_gate #(.TICK(TICK)) irq_gate_i (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpl_event(ev[0]), .err_event(ev[1]),
      .pkt_start(ev[2]), .pkt_end(ev[3]), .irq(irq));
   irq_host_model irq_host_model_i (.mclk(mclk), .resetn(resetn), .irq(irq),
      .rise_cnt_q(rises));
   initial forever #2.5 mclk = ~mclk;
   task automatic check(input string nm, input word_t s, input word_t e);
      samples_checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic chk_irq(input logic e);
      check("irq", {31'h0, irq}, {31'h0, e});
   endtask : chk_irq
   task automatic apb(input logic w, input logic [11:0] a, input word_t d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
         @(posedge mclk);
      while (pready !== 1'b1 && ++n < 100);
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 100)
         fail_count++;
   endtask : apb
   task automatic pulse(input logic [3:0] m);
      @(posedge mclk);
      ev <= m;
      @(posedge mclk);
      ev <= 4'h0;
   endtask : pulse
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      complete_run();
   end
   initial
   begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      apb(1'b0, `OFF_CTRL, 32'h00000000);
      check("ctrl reset", rd, `CTRL_RESET);
      check("ctrl err", {31'h0, slverr}, 32'h00000000);
      apb(1'b1, `OFF_CTRL, 32'hffffffff);
      apb(1'b0, `OFF_CTRL, 32'h00000000);
      check("ctrl bits", rd, `CTRL_WMASK);
      apb(1'b0, 12'h010, 32'h00000000);
      check("unmapped", rd, 32'h00000000);
      check("unmapped err", {31'h0, slverr}, 32'h00000001);
      $display("register test done");
      for (int i = 0; i < 2; i++)
         for (int m = 0; m < 2; m++)
         begin
            apb(1'b1, `OFF_MASK, (m == 1) ? 32'h00000000 : 32'h00000007);
            apb(1'b1, `OFF_CTRL, 32'h00010000 | ((m == 1) ? (32'h1 << (12 + 2 * i)) : 32'h0));
            pulse(i ? 4'h2 : 4'h1);
            repeat (2) @(posedge mclk);
            chk_irq(1'b0);
            apb(1'b1, `OFF_MASK, 32'h00000007);
            repeat (2) @(posedge mclk);
            chk_irq(m == 1);
            apb(1'b1, `OFF_STATUS, 32'h00000007);
            repeat (2) @(posedge mclk);
            chk_irq(1'b0);
         end
      apb(1'b1, `OFF_CTRL, 32'h01012000);
      pulse(4'h8);
      repeat (30) @(posedge mclk);
      chk_irq(1'b0);
      $display("direct mode test done");
      apb(1'b1, `OFF_MODE, 32'h00000001);
      apb(1'b1, `OFF_CTRL, 32'h00021000);
      pulse(4'h1);
      repeat (2) @(posedge mclk);
      chk_irq(1'b0);
      pulse(4'h1);
      repeat (2) @(posedge mclk);
      chk_irq(1'b1);
      apb(1'b1, `OFF_STATUS, 32'h00000007);
      apb(1'b1, `OFF_CTRL, 32'h01012000);
      pulse(4'h4);
      pulse(4'h8);
      repeat (2) @(posedge mclk);
      chk_irq(1'b0);
      n = 0;
      while (irq !== 1'b1 && n < 30)
      begin
         @(posedge mclk);
         n++;
      end
      chk_irq(1'b1);
      apb(1'b1, `OFF_MODE, 32'h00000000);
      repeat (2) @(posedge mclk);
      chk_irq(1'b0);
      apb(1'b1, `OFF_STATUS, 32'h00000007);
      apb(1'b1, `OFF_MODE, 32'h00000001);
      pulse(4'h8);
      pulse(4'h4);
      repeat (30) @(posedge mclk);
      chk_irq(1'b0);
      check("host rises", {24'h0, rises}, 32'h00000004);
      apb(1'b1, `OFF_CTRL, 32'h00014000);
      pulse(4'h2);
      repeat (2) @(posedge mclk);
      chk_irq(1'b1);
      $display("scatter-gather test done");
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      apb(1'b0, `OFF_CTRL, 32'h00000000);
      check("ctrl rereset", rd, `CTRL_RESET);
      chk_irq(1'b0);
      $display("second reset test done");
      complete_run();
   end
endmodule : tb
`default_nettype wire
